// >>> hw/sfr_pkg.sv
`default_nettype none
package sfr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] stack_pointer_low_off = 8'h81;
  localparam logic [7:0] pointer0_low_byte_off = 8'h82;
  localparam logic [7:0] pointer0_high_byte_off = 8'h83;
  localparam logic [7:0] pointer1_low_byte_off = 8'h84;
  localparam logic [7:0] pointer1_high_byte_off = 8'h85;
  localparam logic [7:0] pointer_select_control_off = 8'h86;
  localparam logic [7:0] flash_wait_cycles_off = 8'h92;
  localparam logic [7:0] pointer0_top_byte_off = 8'h93;
  localparam logic [7:0] pointer1_top_byte_off = 8'h95;
  localparam logic [7:0] stack_pointer_high_off = 8'h9b;
  localparam logic [7:0] address_mode_control_off = 8'h9d;
  localparam logic [7:0] port_two_latch_off = 8'ha0;
  localparam logic [7:0] core_activity_status_off = 8'hc5;
  localparam logic [7:0] xram_base_relocation_off = 8'hc6;
  localparam logic [7:0] program_status_word_off = 8'hd0;
  localparam logic [7:0] indirect_high_byte_off = 8'hda;
  localparam logic [7:0] indirect_top_byte_off = 8'hea;
  localparam logic [7:0] arith_aux_register_off = 8'hf0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] zero_rst = 8'h00;
  localparam logic [3:0] flash_wait_rst = 4'h7;
  localparam logic [7:0] port_two_rst = 8'hff;
  // ==========================================================
  // Field positions
  localparam int psw_carry_bit = 7;
  localparam int psw_half_carry_bit = 6;
  localparam int psw_general_bit = 5;
  localparam int psw_bank_lsb = 3;
  localparam int psw_overflow_bit = 2;
  localparam int psw_user_bit = 1;
  localparam int psw_parity_bit = 0;
  localparam int stat_high_prio_bit = 6;
  localparam int stat_low_prio_bit = 5;
  localparam int stat_s1_tx_bit = 3;
  localparam int stat_s1_rx_bit = 2;
  localparam int stat_s0_tx_bit = 1;
  localparam int stat_s0_rx_bit = 0;
  localparam int amc_vector_bit = 5;
  localparam int amc_override_bit = 3;
  localparam int amc_ext_stack_bit = 2;
  localparam int amc_mode_lsb = 0;
  localparam int psc_step1_bit = 7;
  localparam int psc_step0_bit = 6;
  localparam int psc_toggle_bit = 5;
  localparam int psc_select_bit = 0;
  localparam logic [7:0] amc_write_mask = 8'h2b;
  localparam logic [7:0] psc_write_mask = 8'he1;
  localparam logic [3:0] vector_high_nibble = 4'hb;
endpackage : sfr_pkg
`default_nettype wire

// >>> hw/cpu_pointer_sfrs.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Auxiliary arithmetic register, reset zero, read/write.
// - Status word holds carry, flags, bank, parity.
// - Push writes at SP+1, pop reads SP.
// - Flat mode stack address is high:low pointer.
// - Read-only priority-active bits, writes ignored.
// - Serial activity bits reported while active.
// - Wait nibble sets flash wait cycles.
// - Wait setting resets to seven.
// - Relocation register stored, software keeps zero.
// - Sixteen_bit_mode sixteen-bit, flat twenty-bit program space.
// - Mode 00 sixteen_bit_mode, bit1 set flat.
// - Read-only extended stack indicator bit.
// - Vector relocate bit moves vectors high.
// - Indirect high byte from port or override.
// - Indirect top byte from extension register.
// - Pointer moves use selected pointer bytes.
// - Select bit picks pointer, reads back, resets.
// - Step direction bits per pointer.
// - Auto toggle flips select after pointer use.
// - Flat mode carries into top byte.
module cpu_pointer_sfrs
  import sfr_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic timed_unlock, // Protected write enable
  input wire logic push, // Stack push request
  input wire logic pop, // Stack pop request
  output logic [15:0] stack_addr, // Stack memory address
  output logic stack_wr, // Stack write strobe
  output logic stack_rd, // Stack read strobe
  input wire logic [7:0] psw_flags_in, // Flags from ALU
  input wire logic psw_flags_we, // Flag update strobe
  input wire logic [7:0] aux_in, // Mul/div result byte
  input wire logic aux_we, // Mul/div result strobe
  input wire logic high_prio_active, // High priority in service
  input wire logic low_prio_active, // Low priority in service
  input wire logic serial1_tx_active, // Serial 1 transmitting
  input wire logic serial1_rx_active, // Serial 1 receiving
  input wire logic serial0_tx_active, // Serial 0 transmitting
  input wire logic serial0_rx_active, // Serial 0 receiving
  input wire logic ext_stack_in, // Extended stack mode indicator
  input wire logic ptr_step, // Pointer increment instruction
  input wire logic ptr_used, // Any pointer instruction executed
  input wire logic flash_rd, // Program flash read start
  output logic flash_ready, // Flash read may complete
  output logic [3:0] flash_wait, // Wait states per flash read
  output logic flat_mode, // Twenty-bit program space
  output logic [19:0] prog_addr_mask, // Program address mask
  output logic [3:0] vector_base, // Vector region high nibble
  output logic [23:0] indirect_addr_hi, // Indirect move bits 23:8
  output logic [23:0] pointer_addr, // Pointer move address
  output logic [7:0] aux_out, // Aux register to ALU
  output logic [7:0] psw_out, // Status word to core
  output logic [7:0] xram_base // Relocation value
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    wait_idle = 2'b01,
    wait_count = 2'b10
  } wait_state_t;

  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] program_status_word;
    logic [7:0] sp_lo;
    logic [7:0] sp_hi;
    logic [23:0] ptr0;
    logic [23:0] ptr1;
    logic [7:0] psc;
    logic [3:0] wait_cfg;
    logic [7:0] amc;
    logic [7:0] reloc;
    logic [7:0] ind_hi;
    logic [7:0] ind_top;
    logic [7:0] port2;
    logic [7:0] rdata;
    logic [3:0] wcnt;
    wait_state_t wst;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic dec,
                                           input logic flat);
    logic [23:0] r;
    r = dec ? p - 24'h00_0001 : p + 24'h00_0001;
    // Top byte only joins the arithmetic in flat mode
    if (!flat) begin
      r[23:16] = p[23:16];
    end
    return r;
  endfunction

  function automatic logic [7:0] status_word(input logic hp, input logic lp,
                                             input logic t1, input logic r1,
                                             input logic t0, input logic r0);
    logic [7:0] s;
    s = 8'h00;
    s[stat_high_prio_bit] = hp;
    s[stat_low_prio_bit] = lp;
    s[stat_s1_tx_bit] = t1;
    s[stat_s1_rx_bit] = r1;
    s[stat_s0_tx_bit] = t0;
    s[stat_s0_rx_bit] = r0;
    return s;
  endfunction

  logic sel;
  logic is_flat;
  logic [7:0] amc_view;
  assign sel = cur_r.psc[psc_select_bit];
  assign is_flat = cur_r.amc[amc_mode_lsb + 1];

  always_comb begin
    amc_view = cur_r.amc;
    amc_view[amc_ext_stack_bit] = ext_stack_in;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] sp_inc;
    logic dir;
    sp_inc = cur_r.sp_lo + 8'h01;
    dir = 1'b0;
    cur_nxt = cur_r;
    cur_nxt.rdata = 8'h00;

    // ==========================================================
    // Core updates
    // Core side updates first; software writes below take priority
    if (aux_we) begin
      cur_nxt.aux = aux_in;
    end
    if (psw_flags_we) begin
      cur_nxt.program_status_word = psw_flags_in;
    end

    // ==========================================================
    // Stack
    if (push) begin
      cur_nxt.sp_lo = sp_inc;
      if (is_flat && sp_inc == 8'h00) begin
        cur_nxt.sp_hi = cur_r.sp_hi + 8'h01;
      end
    end else if (pop) begin
      cur_nxt.sp_lo = cur_r.sp_lo - 8'h01;
      if (is_flat && cur_r.sp_lo == 8'h00) begin
        cur_nxt.sp_hi = cur_r.sp_hi - 8'h01;
      end
    end

    // ==========================================================
    // Pointer stepping
    if (ptr_step) begin
      dir = sel ? cur_r.psc[psc_step1_bit] : cur_r.psc[psc_step0_bit];
      if (sel) begin
        cur_nxt.ptr1 = step_ptr(cur_r.ptr1, dir, is_flat);
      end else begin
        cur_nxt.ptr0 = step_ptr(cur_r.ptr0, dir, is_flat);
      end
    end
    if ((ptr_used || ptr_step) && cur_r.psc[psc_toggle_bit]) begin
      cur_nxt.psc[psc_select_bit] = ~sel;
    end

    // ==========================================================
    // Software writes
    if (wr) begin
      case (addr)
        arith_aux_register_off: begin
          cur_nxt.aux = wdata;
        end
        program_status_word_off: begin
          cur_nxt.program_status_word = wdata;
        end
        stack_pointer_low_off: begin
          cur_nxt.sp_lo = wdata;
        end
        stack_pointer_high_off: begin
          cur_nxt.sp_hi = wdata;
        end
        pointer0_low_byte_off: begin
          cur_nxt.ptr0[7:0] = wdata;
        end
        pointer0_high_byte_off: begin
          cur_nxt.ptr0[15:8] = wdata;
        end
        pointer0_top_byte_off: begin
          cur_nxt.ptr0[23:16] = wdata;
        end
        pointer1_low_byte_off: begin
          cur_nxt.ptr1[7:0] = wdata;
        end
        pointer1_high_byte_off: begin
          cur_nxt.ptr1[15:8] = wdata;
        end
        pointer1_top_byte_off: begin
          cur_nxt.ptr1[23:16] = wdata;
        end
        pointer_select_control_off: begin
          cur_nxt.psc = wdata & psc_write_mask;
        end
        port_two_latch_off: begin
          cur_nxt.port2 = wdata;
        end
        indirect_high_byte_off: begin
          cur_nxt.ind_hi = wdata;
        end
        indirect_top_byte_off: begin
          cur_nxt.ind_top = wdata;
        end
        flash_wait_cycles_off: begin
          if (timed_unlock) begin
            cur_nxt.wait_cfg = wdata[3:0];
          end
        end
        xram_base_relocation_off: begin
          if (timed_unlock) begin
            cur_nxt.reloc = wdata;
          end
        end
        address_mode_control_off: begin
          if (timed_unlock) begin
            cur_nxt.amc = wdata & amc_write_mask;
          end
        end
        default: begin
        end
      endcase
    end
    // Status register has no write path at all

    // ==========================================================
    // Software reads
    if (rd) begin
      case (addr)
        arith_aux_register_off: begin
          cur_nxt.rdata = cur_r.aux;
        end
        program_status_word_off: begin
          cur_nxt.rdata = cur_r.program_status_word;
        end
        stack_pointer_low_off: begin
          cur_nxt.rdata = cur_r.sp_lo;
        end
        stack_pointer_high_off: begin
          cur_nxt.rdata = cur_r.sp_hi;
        end
        pointer0_low_byte_off: begin
          cur_nxt.rdata = cur_r.ptr0[7:0];
        end
        pointer0_high_byte_off: begin
          cur_nxt.rdata = cur_r.ptr0[15:8];
        end
        pointer0_top_byte_off: begin
          cur_nxt.rdata = cur_r.ptr0[23:16];
        end
        pointer1_low_byte_off: begin
          cur_nxt.rdata = cur_r.ptr1[7:0];
        end
        pointer1_high_byte_off: begin
          cur_nxt.rdata = cur_r.ptr1[15:8];
        end
        pointer1_top_byte_off: begin
          cur_nxt.rdata = cur_r.ptr1[23:16];
        end
        pointer_select_control_off: begin
          cur_nxt.rdata = cur_r.psc;
        end
        port_two_latch_off: begin
          cur_nxt.rdata = cur_r.port2;
        end
        indirect_high_byte_off: begin
          cur_nxt.rdata = cur_r.ind_hi;
        end
        indirect_top_byte_off: begin
          cur_nxt.rdata = cur_r.ind_top;
        end
        flash_wait_cycles_off: begin
          cur_nxt.rdata = {4'h0, cur_r.wait_cfg};
        end
        xram_base_relocation_off: begin
          cur_nxt.rdata = cur_r.reloc;
        end
        address_mode_control_off: begin
          cur_nxt.rdata = amc_view;
        end
        core_activity_status_off: begin
          cur_nxt.rdata = status_word(high_prio_active, low_prio_active,
                                      serial1_tx_active, serial1_rx_active,
                                      serial0_tx_active, serial0_rx_active);
        end
        default: cur_nxt.rdata = 8'h00;
      endcase
    end

    // ==========================================================
    // Flash wait sequencer: cfg wait cycles, the first in the flash_rd cycle
    case (cur_r.wst)
      wait_idle: begin
        if (flash_rd && cur_r.wait_cfg != 4'h0) begin
          cur_nxt.wcnt = cur_r.wait_cfg - 4'h1;
          cur_nxt.wst = wait_count;
        end
      end
      wait_count: begin
        if (cur_r.wcnt == 4'h0) begin
          cur_nxt.wst = wait_idle;
        end else begin
          cur_nxt.wcnt = cur_r.wcnt - 4'h1;
        end
      end
      default: cur_nxt.wst = wait_idle;
    endcase

    // ==========================================================
    // Reset, last so it overrides every update above
    if (rst) begin
      cur_nxt = '0;
      cur_nxt.wait_cfg = flash_wait_rst;
      cur_nxt.port2 = port_two_rst;
      cur_nxt.reloc = zero_rst;
      cur_nxt.wst = wait_idle;
    end
  end

  always_ff @(posedge clock) begin
    cur_r <= cur_nxt;
  end

  // ==========================================================
  // Outputs
  assign rdata = cur_r.rdata;
  assign aux_out = cur_r.aux;
  assign psw_out = cur_r.program_status_word;
  assign xram_base = cur_r.reloc;
  assign flash_wait = cur_r.wait_cfg;

  // Combinational so a zero-wait fetch ends in its own cycle
  assign flash_ready = (cur_r.wst == wait_idle) ? (!flash_rd || cur_r.wait_cfg == 4'h0)
                       : (cur_r.wcnt == 4'h0);

  assign flat_mode = is_flat;
  assign prog_addr_mask = is_flat ? 20'hF_FFFF : 20'h0_FFFF;
  assign vector_base = cur_r.amc[amc_vector_bit] ? vector_high_nibble : 4'h0;

  // Low byte is the core's register operand, left as zero here
  assign indirect_addr_hi = {cur_r.ind_top,
                             cur_r.amc[amc_override_bit] ? cur_r.ind_hi : cur_r.port2,
                             8'h00};
  assign pointer_addr = sel ? cur_r.ptr1 : cur_r.ptr0;

  // Push wins when both strobes arrive together
  assign stack_wr = push;
  assign stack_rd = pop && !push;
  assign stack_addr = push ? {is_flat ? cur_r.sp_hi : 8'h00, cur_r.sp_lo + 8'h01}
                      : {is_flat ? cur_r.sp_hi : 8'h00, cur_r.sp_lo};
endmodule // cpu_pointer_sfrs
`default_nettype wire

// >>> tb/flash_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Core side of one program flash fetch
module flash_fetch_model (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset
  input wire logic start, // Begin one fetch
  input wire logic flash_ready, // Fetch may finish
  output logic flash_rd, // Fetch start pulse
  output logic [4:0] waited, // Wait cycles seen
  output logic busy // Fetch in flight
);
  always_ff @(posedge clock) begin
    if (rst) begin
      flash_rd <= 1'b0;
      busy <= 1'b0;
      waited <= 5'h00;
    end else if (start && !busy) begin
      flash_rd <= 1'b1;
      busy <= 1'b1;
      waited <= 5'h00;
    end else if (busy) begin
      flash_rd <= 1'b0;
      // Each low cycle of ready is one wait state
      if (flash_ready) busy <= 1'b0;
      else waited <= waited + 5'h01;
    end
  end
endmodule // flash_fetch_model
`default_nettype wire

// >>> tb/sfr_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sfr_chk (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic timed_unlock, // Protected write enable
  input wire logic push, // Stack push
  input wire logic [15:0] stack_addr, // Stack address
  input wire logic stack_wr, // Stack write
  input wire logic high_prio_active, // High priority busy
  input wire logic serial0_rx_active, // Serial 0 receiving
  input wire logic flash_rd, // Flash fetch start
  input wire logic flash_ready, // Flash fetch may end
  input wire logic [3:0] flash_wait, // Wait setting
  input wire logic flat_mode, // Wide program space
  input wire logic [3:0] vector_base, // Vector region
  input wire logic [23:0] indirect_addr_hi, // Indirect upper bits
  input wire logic [7:0] aux_out // Aux register
);
  // ==========================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_wait_write: assert property (wr && addr == 8'h92 && timed_unlock
    |=> flash_wait == $past(wdata[3:0])) else $error("wait setting not taken");
  a_wait_locked: assert property (wr && addr == 8'h92 && !timed_unlock
    |=> $stable(flash_wait)) else $error("locked wait setting changed");
  a_wait_seven: assert property (flash_rd && flash_wait == 4'h7
    |-> !flash_ready [*7] ##1 flash_ready) else $error("seven wait fetch wrong");
  a_zero_wait: assert property (flash_rd && flash_wait == 4'h0
    |-> flash_ready) else $error("zero wait fetch stalled");
  a_mode_select: assert property (wr && addr == 8'h9d && timed_unlock
    |=> flat_mode == $past(wdata[1])) else $error("address mode wrong");
  a_vector_region: assert property (wr && addr == 8'h9d && timed_unlock
    |=> vector_base == ($past(wdata[5]) ? 4'hb : 4'h0)) else $error("vector region wrong");
  a_status_read: assert property (rd && addr == 8'hc5 |=> rdata[6] == $past(high_prio_active)
    && rdata[0] == $past(serial0_rx_active) && rdata[7] == 1'b0) else $error("status read wrong");
  a_push_sixteen_bit_mode: assert property (push && !flat_mode
    |-> stack_wr && stack_addr[15:8] == 8'h00) else $error("push address wrong");
  a_top_byte: assert property (wr && addr == 8'hea
    |=> indirect_addr_hi[23:16] == $past(wdata)) else $error("indirect top byte wrong");
  a_aux_write: assert property (wr && addr == 8'hf0
    |=> aux_out == $past(wdata)) else $error("aux write lost");
endmodule // sfr_chk
bind cpu_pointer_sfrs sfr_chk i_sfr_chk (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .timed_unlock(timed_unlock), .push(push),
  .stack_addr(stack_addr), .stack_wr(stack_wr), .high_prio_active(high_prio_active),
  .serial0_rx_active(serial0_rx_active), .flash_rd(flash_rd), .flash_ready(flash_ready),
  .flash_wait(flash_wait), .flat_mode(flat_mode), .vector_base(vector_base),
  .indirect_addr_hi(indirect_addr_hi), .aux_out(aux_out));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sfr_pkg::*;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
  logic clock = 0, rst = 1, wr = 0, rd = 0, timed_unlock = 0, push = 0, pop = 0, start = 0;
  logic psw_flags_we = 0, aux_we = 0, ext_stack_in = 0, ptr_step = 0, ptr_used = 0;
  logic [7:0] addr = 0, wdata = 0, psw_flags_in = 0, aux_in = 0, rdata, aux_out, psw_out, xbase;
  logic [5:0] act = 0;
  logic flash_rd, flash_ready, busy, stack_wr, stack_rd, flat_mode;
  logic [4:0] waited;
  logic [15:0] stack_addr;
  logic [3:0] flash_wait, vector_base;
  logic [19:0] mask;
  logic [23:0] ind_hi, ptr_addr;
  int mismatches = 0, compares = 0;
  cpu_pointer_sfrs i_cpu_pointer_sfrs (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timed_unlock(timed_unlock), .push(push), .pop(pop),
    .stack_addr(stack_addr), .stack_wr(stack_wr), .stack_rd(stack_rd),
    .psw_flags_in(psw_flags_in), .psw_flags_we(psw_flags_we), .aux_in(aux_in), .aux_we(aux_we),
    .high_prio_active(act[5]), .low_prio_active(act[4]), .serial1_tx_active(act[3]),
    .serial1_rx_active(act[2]), .serial0_tx_active(act[1]), .serial0_rx_active(act[0]),
    .ext_stack_in(ext_stack_in), .ptr_step(ptr_step), .ptr_used(ptr_used), .flash_rd(flash_rd),
    .flash_ready(flash_ready), .flash_wait(flash_wait), .flat_mode(flat_mode),
    .prog_addr_mask(mask), .vector_base(vector_base), .indirect_addr_hi(ind_hi),
    .pointer_addr(ptr_addr), .aux_out(aux_out), .psw_out(psw_out), .xram_base(xbase));
  flash_fetch_model i_flash_fetch_model (.clock(clock), .rst(rst), .start(start),
    .flash_ready(flash_ready), .flash_rd(flash_rd), .waited(waited), .busy(busy));
  initial forever #2.5 clock = ~clock;
  // ==========================================
  // Bus and strobe helpers
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic u = 1'b0);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    timed_unlock <= u;
    @(posedge clock);
    wr <= 1'b0;
    timed_unlock <= 1'b0;
    #1;
  endtask
  task automatic prot(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask
  task automatic look(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  // Order: aux_we, psw_flags_we, ptr_used, ptr_step
  task automatic fire(input logic [3:0] w);
    @(posedge clock);
    {aux_we, psw_flags_we, ptr_used, ptr_step} <= w;
    @(posedge clock);
    {aux_we, psw_flags_we, ptr_used, ptr_step} <= 4'h0;
    #1;
  endtask
  task automatic flash(input logic [3:0] n);
    int k;
    prot(8'h92, {4'h0, n});
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (busy && k < 40);
    `CHK("fetch end", 1'b0, busy)
    `CHK("fetch wait", {1'b0, n}, waited)
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] offs [16] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92, 8'h9b,
      8'h9d, 8'hc5, 8'hc6, 8'hd0, 8'hda, 8'hea, 8'hf0, 8'h80};
    logic [7:0] rw [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h9b, 8'hd0, 8'hda, 8'hea, 8'hf0};
    foreach (offs[i]) look(offs[i], (offs[i] == 8'h92) ? 8'h07 : 8'h00, "reset value");
    foreach (rw[i]) put(rw[i], rw[i] ^ 8'h5a);
    foreach (rw[i]) look(rw[i], rw[i] ^ 8'h5a, "read back");
  endtask
  task automatic t_protect;
    put(8'h92, 8'h03);
    look(8'h92, 8'h07, "locked wait");
    prot(8'hc6, 8'h11);
    `CHK("relocation", 8'h11, xbase)
    prot(8'hc6, 8'h00);
    ext_stack_in <= 1'b1;
    prot(8'h9d, 8'hff);
    look(8'h9d, 8'h2f, "mode control");
    `CHK("wide mask", 20'hfffff, mask)
    prot(8'h9d, 8'h00);
    `CHK("narrow mask", 20'h0ffff, mask)
  endtask
  task automatic t_status;
    logic [5:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 6'h01 << i;
      act <= v;
      put(8'hc5, 8'hff);
      look(8'hc5, {1'b0, v[5:4], 1'b0, v[3:0]}, "activity");
    end
  endtask
  task automatic t_pointers;
    logic dec;
    put(8'h86, 8'hff);
    look(8'h86, 8'he1, "select reg");
    for (int m = 0; m < 8; m++) begin
      dec = m[0] ? m[2] : m[1];
      put(m[0] ? 8'h84 : 8'h82, 8'h00);
      put(m[0] ? 8'h85 : 8'h83, 8'h10);
      put(8'h86, {m[2:1], 5'h00, m[0]});
      fire(4'h1);
      `CHK("step", dec ? 24'h000fff : 24'h001001, ptr_addr)
    end
    put(8'h86, 8'h20);
    fire(4'h2);
    look(8'h86, 8'h21, "toggle");
    prot(8'h9d, 8'h02);
    put(8'h86, 8'h00);
    put(8'h82, 8'hff);
    put(8'h83, 8'hff);
    fire(4'h1);
    `CHK("flat carry", 24'h010000, ptr_addr)
    prot(8'h9d, 8'h00);
    put(8'h93, 8'h00);
    put(8'h82, 8'hff);
    put(8'h83, 8'hff);
    fire(4'h1);
    `CHK("sixteen_bit_mode wrap", 24'h000000, ptr_addr)
  endtask
  task automatic t_moves;
    put(8'hda, 8'h12);
    put(8'hea, 8'h34);
    `CHK("port high", 24'h34ff00, ind_hi)
    prot(8'h9d, 8'h08);
    `CHK("override high", 24'h341200, ind_hi)
    put(8'h81, 8'h20);
    @(posedge clock);
    push <= 1'b1;
    #1;
    `CHK("push addr", 16'h0021, stack_addr)
    @(posedge clock);
    push <= 1'b0;
    pop <= 1'b1;
    #1;
    `CHK("pop addr", 16'h0021, stack_addr)
    `CHK("pop strobe", 1'b1, stack_rd)
    @(posedge clock);
    pop <= 1'b0;
    prot(8'h9d, 8'h02);
    put(8'h9b, 8'h12);
    @(posedge clock);
    pop <= 1'b1;
    #1;
    `CHK("flat pop", 16'h1220, stack_addr)
    @(posedge clock);
    pop <= 1'b0;
    prot(8'h9d, 8'h00);
    aux_in <= 8'h5a;
    psw_flags_in <= 8'hc3;
    fire(4'hc);
    look(8'hf0, 8'h5a, "aux update");
    look(8'hd0, 8'hc3, "flag update");
    `CHK("flag out", 8'hc3, psw_out)
  endtask
  // ==========================================
  // Sequence and verdict
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_protect;
    flash(4'h7);
    flash(4'h0);
    flash(4'hf);
    t_status;
    t_pointers;
    t_moves;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
